// ### common/fbpc_pkg.sv
// Constants and types shared by the flash bus pin control block.
// Function
// RULE1: Output enable low drives data onto bus.
// RULE2: Output enable high floats data and wait.
// RULE3: Reset pin clears automation, rejects all writes.
// RULE4: Leaving reset returns to asynchronous array reads.
// RULE5: Config bit 10 selects wait polarity.
// RULE6: Wait driven only with chip and output enabled.
// RULE7: Synchronous reads: wait asserted while data invalid.
// RULE8: Async page and writes keep wait deasserted.
// RULE9: Address and data captured on write strobe rise.
// RULE10: Protect low: locked-down blocks refuse unlock.
// RULE11: Protect high: lock-down status is ignored.
// RULE12: Program supply lockout leaves array contents unchanged.
// RULE13: Core supply lockout inhibits all array writes.
// RULE14: Chip enable high deselects, floats data, wait.
// RULE15: Sync: latch on valid rise or clock edge.
// RULE16: Async: address flows while valid low, latches.
// RULE17: Rejected writes leave command state and array unchanged.
package fbpc_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int BLK_W = 4;
  localparam int NUM_BLK = 16;
  localparam int LAT_W = 3;

  // ==========================================================
  // Register port offsets and fields
  localparam logic [3:0] OFS_RCR = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_LAST_ADDR = 4'h8;
  localparam logic [3:0] OFS_LAST_DATA = 4'hc;
  localparam logic [DATA_W-1:0] RCR_RESET = 16'h2000;
  localparam int RCR_SYNC_BIT = 15;
  localparam int RCR_LAT_LSB = 11;
  localparam int RCR_WAIT_POL_BIT = 10;

  // Status bits; 5 to 7 are sticky and cleared by writing ones.
  localparam int ST_RST = 0;
  localparam int ST_PROG_LKO = 1;
  localparam int ST_CORE_LKO = 2;
  localparam int ST_WP = 3;
  localparam int ST_WAIT = 4;
  localparam int ST_REJECT = 5;
  localparam int ST_LOCK_REF = 6;
  localparam int ST_PE_REF = 7;
  localparam int ST_READY = 8;
  localparam logic [DATA_W-1:0] ST_STICKY_MASK = 16'h00e0;

  // ==========================================================
  // Bus command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'ha1;
  localparam logic [7:0] CMD_READ_STATUS = 8'ha2;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'ha3;
  localparam logic [7:0] CMD_PROG_SETUP = 8'ha4;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'ha5;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hc0;
  localparam logic [7:0] CMD_LOCK = 8'hc1;
  localparam logic [7:0] CMD_UNLOCK = 8'hc2;
  localparam logic [7:0] CMD_LOCK_DOWN = 8'hc3;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    LK_LOCK,
    LK_UNLOCK,
    LK_DOWN
  } fbpc_lock_op_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic address_valid_n;
    logic rst_n;
    logic wp_n;
    logic bclk;
  } fbpc_pins_t;

  typedef struct packed {
    logic valid;
    logic erase;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fbpc_arr_req_t;

  function automatic logic [BLK_W-1:0] fbpc_blk_of(
    input logic [ADDR_W-1:0] a
  );
    return a[ADDR_W-1 -: BLK_W];
  endfunction : fbpc_blk_of

endpackage : fbpc_pkg

// ### hw/fbpc_flash_bus_ctrl.sv
// Pin-level bus control of a parallel flash device: read, wait, write.
`timescale 1ns/1ps
module fbpc_flash_bus_ctrl
  import fbpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Flash bus pins
  input wire fbpc_pins_t pins_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic wait_o,
  output logic wait_oe_o,
  // Supply monitors, high while at or below the lockout level
  input wire logic program_supply_lockout_level_i,
  input wire logic core_lockout_level_i,
  // Array side
  output logic [ADDR_W-1:0] rd_addr_o,
  input wire logic [DATA_W-1:0] rd_data_i,
  input wire logic arr_busy_i,
  output fbpc_arr_req_t arr_req_o,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o
);

  typedef enum logic [1:0] {
    CS_IDLE,
    CS_LOCK,
    CS_PROG,
    CS_ERASE
  } fbpc_cmd_state_t;

  // ==========================================================
  // Input synchronisers
  fbpc_pins_t pin_s1_reg;
  fbpc_pins_t pin_s2_reg;
  fbpc_pins_t pin_prev_reg;
  logic [ADDR_W-1:0] addr_s1_reg;
  logic [ADDR_W-1:0] addr_s2_reg;
  logic [DATA_W-1:0] dq_s1_reg;
  logic [DATA_W-1:0] dq_s2_reg;
  logic [1:0] lko_s1_reg;
  logic [1:0] lko_s2_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_s1_reg <= '1;
      pin_s2_reg <= '1;
      pin_prev_reg <= '1;
    end else begin
      pin_s1_reg <= pins_i;
      pin_s2_reg <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      addr_s1_reg <= '0;
      addr_s2_reg <= '0;
      dq_s1_reg <= '0;
      dq_s2_reg <= '0;
      lko_s1_reg <= '1;
      lko_s2_reg <= '1;
    end else begin
      addr_s1_reg <= addr_i;
      addr_s2_reg <= addr_s1_reg;
      dq_s1_reg <= dq_i;
      dq_s2_reg <= dq_s1_reg;
      lko_s1_reg <= {program_supply_lockout_level_i, core_lockout_level_i};
      lko_s2_reg <= lko_s1_reg;
    end
  end

  // ==========================================================
  // Decoded pin state
  logic flash_rst;
  logic sel;
  logic reading;
  logic we_rise;
  logic adv_rise;
  logic adv_fall;
  logic bclk_rise;
  logic lockout;

  assign flash_rst = !pin_s2_reg.rst_n;
  assign sel = !pin_s2_reg.ce_n;
  assign reading = sel && !pin_s2_reg.oe_n && pin_s2_reg.we_n;
  assign we_rise = pin_s2_reg.we_n && !pin_prev_reg.we_n;
  assign adv_rise = pin_s2_reg.address_valid_n
                    && !pin_prev_reg.address_valid_n;
  assign adv_fall = !pin_s2_reg.address_valid_n
                    && pin_prev_reg.address_valid_n;
  assign bclk_rise = pin_s2_reg.bclk && !pin_prev_reg.bclk;
  assign lockout = |lko_s2_reg; // RULE12 RULE13

  // ==========================================================
  // Read configuration register
  logic [DATA_W-1:0] read_config_reg;
  logic sync_mode;
  logic wait_polarity;

  assign sync_mode = read_config_reg[RCR_SYNC_BIT];
  assign wait_polarity = read_config_reg[RCR_WAIT_POL_BIT];

  always_ff @(posedge clk_i) begin
    if (srst_i || flash_rst) begin
      read_config_reg <= RCR_RESET; // RULE4
    end else if (reg_wr_i && reg_addr_i == OFS_RCR) begin
      read_config_reg <= reg_wdata_i;
    end
  end

  // ==========================================================
  // Address latch and burst counter
  // The synchronous path counts edges of the sampled bus clock, so the
  // bus clock must stay well below half of clk_i.
  logic [ADDR_W-1:0] addr_q_reg;
  logic latched_reg;
  logic [LAT_W-1:0] lat_cnt_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i || flash_rst) begin
      addr_q_reg <= '0;
      latched_reg <= 1'b0;
      lat_cnt_reg <= '0;
    end else if (!sync_mode) begin
      latched_reg <= 1'b0;
      lat_cnt_reg <= '0;
      if (!pin_s2_reg.address_valid_n) begin
        addr_q_reg <= addr_s2_reg; // RULE16
      end
    end else if (!latched_reg || adv_fall || !sel) begin
      if (!pin_s2_reg.address_valid_n) begin
        addr_q_reg <= addr_s2_reg;
      end
      latched_reg <= sel && (adv_rise
                     || (!pin_s2_reg.address_valid_n && bclk_rise)); // RULE15
      lat_cnt_reg <= read_config_reg[RCR_LAT_LSB +: LAT_W];
    end else if (bclk_rise) begin
      if (lat_cnt_reg != '0) begin
        lat_cnt_reg <= lat_cnt_reg - LAT_W'(1);
      end else begin
        addr_q_reg <= addr_q_reg + ADDR_W'(1);
      end
    end
  end

  assign rd_addr_o = addr_q_reg;

  // ==========================================================
  // Write capture
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [DATA_W-1:0] wr_data_reg;
  logic wr_pend_reg;
  logic wr_ok;
  logic wr_reject;

  // A rejected strobe is dropped here, before it can reach the command
  // decoder or the array.
  assign wr_ok = we_rise && sel && !flash_rst && !lockout; // RULE3 RULE17
  assign wr_reject = we_rise && sel && !wr_ok;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
    end else if (wr_ok) begin
      wr_addr_reg <= addr_s2_reg; // RULE9
      wr_data_reg <= dq_s2_reg; // RULE9
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || flash_rst) begin
      wr_pend_reg <= 1'b0;
    end else begin
      wr_pend_reg <= wr_ok && !lockout;
    end
  end

  // ==========================================================
  // Command decoder
  fbpc_cmd_state_t cmd_state_reg;
  logic rd_status_reg;
  logic [7:0] cmd_code;
  logic blk_locked;
  logic lock_refused;
  logic lock_op_valid;
  fbpc_lock_op_t lock_op;
  logic arr_go;

  assign cmd_code = wr_data_reg[7:0];

  always_ff @(posedge clk_i) begin
    if (srst_i || flash_rst) begin
      cmd_state_reg <= CS_IDLE; // RULE3
      rd_status_reg <= 1'b0; // RULE4
    end else if (wr_pend_reg) begin
      case (cmd_state_reg)
        CS_IDLE: begin
          case (cmd_code)
            CMD_READ_ARRAY: rd_status_reg <= 1'b0;
            CMD_READ_STATUS: rd_status_reg <= 1'b1;
            CMD_LOCK_SETUP: cmd_state_reg <= CS_LOCK;
            CMD_PROG_SETUP: begin
              cmd_state_reg <= CS_PROG;
              rd_status_reg <= 1'b1;
            end
            CMD_ERASE_SETUP: begin
              cmd_state_reg <= CS_ERASE;
              rd_status_reg <= 1'b1;
            end
            default: ;
          endcase
        end
        default: cmd_state_reg <= CS_IDLE;
      endcase
    end
  end

  always_comb begin
    lock_op = LK_LOCK;
    lock_op_valid = 1'b0;
    if (wr_pend_reg && cmd_state_reg == CS_LOCK) begin
      lock_op_valid = 1'b1;
      case (cmd_code)
        CMD_LOCK: lock_op = LK_LOCK;
        CMD_UNLOCK: lock_op = LK_UNLOCK;
        CMD_LOCK_DOWN: lock_op = LK_DOWN;
        default: lock_op_valid = 1'b0;
      endcase
    end
  end

  fbpc_lock_table u_lock_table (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .clear_i(flash_rst),
    .op_valid_i(lock_op_valid),
    .op_i(lock_op),
    .blk_i(fbpc_blk_of(wr_addr_reg)),
    .wp_n_i(pin_s2_reg.wp_n),
    .query_blk_i(fbpc_blk_of(wr_addr_reg)),
    .locked_o(blk_locked),
    .refused_o(lock_refused)
  );

  // ==========================================================
  // Array requests
  logic pe_try;

  assign pe_try = wr_pend_reg && ((cmd_state_reg == CS_PROG)
                  || (cmd_state_reg == CS_ERASE
                      && cmd_code == CMD_ERASE_CONFIRM));
  assign arr_go = pe_try && !blk_locked && !lockout; // RULE12 RULE13

  always_ff @(posedge clk_i) begin
    if (srst_i || flash_rst) begin
      arr_req_o <= '0;
    end else begin
      arr_req_o.valid <= arr_go;
      arr_req_o.erase <= cmd_state_reg == CS_ERASE;
      arr_req_o.addr <= wr_addr_reg;
      arr_req_o.data <= wr_data_reg;
    end
  end

  // ==========================================================
  // Status
  logic [DATA_W-1:0] sticky_reg;
  logic [DATA_W-1:0] sticky_set;
  logic [DATA_W-1:0] status_word;
  logic waiting;

  always_comb begin
    sticky_set = '0;
    sticky_set[ST_REJECT] = wr_reject;
    sticky_set[ST_LOCK_REF] = lock_refused;
    sticky_set[ST_PE_REF] = pe_try && !arr_go;
  end

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sticky_reg <= '0;
    end else if (reg_wr_i && reg_addr_i == OFS_STATUS) begin
      sticky_reg <= (sticky_reg & ~reg_wdata_i) | sticky_set;
    end else begin
      sticky_reg <= sticky_reg | sticky_set;
    end
  end

  always_comb begin
    status_word = sticky_reg & ST_STICKY_MASK;
    status_word[ST_RST] = flash_rst;
    status_word[ST_PROG_LKO] = lko_s2_reg[1];
    status_word[ST_CORE_LKO] = lko_s2_reg[0];
    status_word[ST_WP] = pin_s2_reg.wp_n;
    status_word[ST_WAIT] = waiting;
    status_word[ST_READY] = !arr_busy_i;
  end

  // ==========================================================
  // Pin drivers
  // Wait marks invalid data only in a synchronous read; the write strobe
  // low or asynchronous mode keeps it deasserted.
  assign waiting = sync_mode && reading
                   && (!latched_reg || lat_cnt_reg != '0); // RULE7 RULE8

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dq_oe_o <= 1'b0;
      wait_oe_o <= 1'b0;
    end else begin
      dq_oe_o <= reading && !flash_rst; // RULE1 RULE2 RULE14
      wait_oe_o <= sel && !pin_s2_reg.oe_n; // RULE6 RULE2 RULE14
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wait_o <= 1'b0;
      dq_o <= '0;
    end else begin
      wait_o <= waiting ? wait_polarity : !wait_polarity; // RULE5
      dq_o <= rd_status_reg ? status_word : rd_data_i;
    end
  end

  // ==========================================================
  // Register read port
  always_ff @(posedge clk_i) begin
    if (srst_i || !reg_rd_i) begin
      reg_rdata_o <= '0;
    end else begin
      case (reg_addr_i)
        OFS_RCR: reg_rdata_o <= read_config_reg;
        OFS_STATUS: reg_rdata_o <= status_word;
        OFS_LAST_ADDR: reg_rdata_o <= wr_addr_reg[DATA_W-1:0];
        OFS_LAST_DATA: reg_rdata_o <= wr_data_reg;
        default: reg_rdata_o <= '0;
      endcase
    end
  end

endmodule : fbpc_flash_bus_ctrl

// ### hw/fbpc_lock_table.sv
// Per-block lock and lock-down state of the flash bus pin control block.
`timescale 1ns/1ps
module fbpc_lock_table
  import fbpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Control
  input wire logic clear_i,
  input wire logic op_valid_i,
  input wire fbpc_lock_op_t op_i,
  input wire logic [BLK_W-1:0] blk_i,
  input wire logic wp_n_i,
  // Query
  input wire logic [BLK_W-1:0] query_blk_i,
  output logic locked_o,
  output logic refused_o
);

  logic [NUM_BLK-1:0] lock_reg;
  logic [NUM_BLK-1:0] down_reg;
  logic unlock_blocked;

  assign unlock_blocked = down_reg[blk_i] && !wp_n_i; // RULE10 RULE11

  // ==========================================================
  // Lock state
  // All blocks come up locked so a glitching bus cannot alter them.
  always_ff @(posedge clk_i) begin
    if (srst_i || clear_i) begin
      lock_reg <= '1;
      down_reg <= '0;
    end else if (op_valid_i) begin
      case (op_i)
        LK_LOCK: lock_reg[blk_i] <= 1'b1;
        LK_DOWN: begin
          lock_reg[blk_i] <= 1'b1;
          down_reg[blk_i] <= 1'b1;
        end
        LK_UNLOCK: begin
          if (!unlock_blocked) begin
            lock_reg[blk_i] <= 1'b0; // RULE10 RULE11
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || clear_i) begin
      refused_o <= 1'b0;
    end else begin
      refused_o <= op_valid_i && (op_i == LK_UNLOCK) && unlock_blocked;
    end
  end

  assign locked_o = lock_reg[query_blk_i];

endmodule : fbpc_lock_table

// ### test/fbpc_assertions.sv
// Assertions on the pin rules of the flash bus control block.
`timescale 1ns/1ps
module fbpc_checker
  import fbpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Pins and supply monitors
  input wire fbpc_pins_t pins_i,
  input wire logic program_supply_lockout_level_i,
  input wire logic core_lockout_level_i,
  // Outputs and register writes
  input wire logic dq_oe_o,
  input wire logic wait_o,
  input wire logic wait_oe_o,
  input wire fbpc_arr_req_t arr_req_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i
);
  // ==========
  // Clocking
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  // ==========
  // Read configuration shadow; it leads the design by the pin delay.
  logic [DATA_W-1:0] cfg_reg;
  always_ff @(posedge clk_i) begin
    if (srst_i || !pins_i.rst_n) begin
      cfg_reg <= RCR_RESET;
    end else if (reg_wr_i && reg_addr_i == OFS_RCR) begin
      cfg_reg <= reg_wdata_i;
    end
  end
  // ==========
  // Properties
  a_float_desel: assert property (pins_i.ce_n [*4]
    |-> !dq_oe_o && !wait_oe_o) else $error("driven while deselected");
  a_float_oe: assert property (pins_i.oe_n [*4]
    |-> !dq_oe_o && !wait_oe_o) else $error("driven with oe high");
  a_drive_read: assert property ((!pins_i.ce_n && !pins_i.oe_n &&
    pins_i.we_n && pins_i.rst_n) [*4] |-> dq_oe_o && wait_oe_o)
    else $error("read not driven");
  a_wait_async: assert property ((!cfg_reg[RCR_SYNC_BIT]
    && $stable(cfg_reg)) [*4] ##0 wait_oe_o
    |-> wait_o == !cfg_reg[RCR_WAIT_POL_BIT])
    else $error("wait asserted in async mode");
  a_wait_sync: assert property (cfg_reg[RCR_SYNC_BIT]
    && $rose(wait_oe_o) |-> wait_o == cfg_reg[RCR_WAIT_POL_BIT])
    else $error("sync wait");
  a_rst_no_req: assert property (!pins_i.rst_n [*8]
    |-> !arr_req_o.valid) else $error("array request in reset");
  a_prog_lko: assert property (program_supply_lockout_level_i [*8]
    |-> !arr_req_o.valid) else $error("request in program lockout");
  a_core_lko: assert property (core_lockout_level_i [*8]
    |-> !arr_req_o.valid) else $error("request in core lockout");
endmodule : fbpc_checker

bind fbpc_flash_bus_ctrl fbpc_checker i_chk (
  .clk_i(clk_i),
  .srst_i(srst_i),
  .pins_i(pins_i),
  .program_supply_lockout_level_i(program_supply_lockout_level_i),
  .core_lockout_level_i(core_lockout_level_i),
  .dq_oe_o(dq_oe_o),
  .wait_o(wait_o),
  .wait_oe_o(wait_oe_o),
  .arr_req_o(arr_req_o),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i)
);

// ### test/fbpc_host_model.sv
// Host-side driver of the flash bus pins.
`timescale 1ns/1ps
module fbpc_host_model
  import fbpc_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Flash bus pins
  output fbpc_pins_t pins_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] dq_o
);
  // Idle: deselected, address valid low so addresses flow through.
  initial begin
    pins_o = 7'h76;
    addr_o = '0;
    dq_o = 16'h0000;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hold
  // Every edge is held 3 clocks so the two-stage synchronisers see it.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    pins_o.ce_n <= 1'b0;
    addr_o <= a;
    dq_o <= d;
    pins_o.we_n <= 1'b0;
    hold(3);
    pins_o.we_n <= 1'b1;
    hold(3);
    pins_o.ce_n <= 1'b1;
    dq_o <= ~d;
    hold(3);
  endtask : wr
  task automatic rd_on(input logic [ADDR_W-1:0] a);
    pins_o.ce_n <= 1'b0;
    pins_o.oe_n <= 1'b0;
    addr_o <= a;
    hold(6);
  endtask : rd_on
  task automatic bclk_pulse();
    pins_o.bclk <= 1'b1;
    hold(3);
    pins_o.bclk <= 1'b0;
    hold(3);
  endtask : bclk_pulse
endmodule : fbpc_host_model

// ### test/tb_top.sv
// Self-checking bench of the flash bus pin control block.
`timescale 1ns/1ps
module tb_top;
  import fbpc_pkg::*;
  typedef struct {
    logic w;
    logic [3:0] a;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] e;
  } fbpc_row_t;
  localparam logic [ADDR_W-1:0] BA = 22'h040010;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  fbpc_pins_t pins;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] dq_in;
  logic [DATA_W-1:0] dq_out;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] got;
  logic dq_oe;
  logic wait_o;
  logic wait_oe;
  logic lko_p;
  logic lko_c;
  logic busy;
  logic [3:0] ra;
  logic [DATA_W-1:0] wd;
  logic wr;
  logic rd;
  fbpc_arr_req_t req;
  fbpc_arr_req_t last_req;
  int fails = 0;
  int n_compared = 0;
  int n_req = 0;
  int cyc = 0;
  fbpc_row_t rows [6] = '{
    '{1'b0, OFS_RCR, 16'h0000, RCR_RESET},
    '{1'b1, OFS_RCR, 16'h2400, 16'h0000},
    '{1'b0, OFS_RCR, 16'h0000, 16'h2400},
    '{1'b1, OFS_LAST_ADDR, 16'hffff, 16'h0000},
    '{1'b0, OFS_LAST_ADDR, 16'h0000, 16'h0000},
    '{1'b0, 4'h2, 16'h0000, 16'h0000}
  };

  function automatic logic [DATA_W-1:0] arr(input logic [ADDR_W-1:0] a);
    return a[15:0] ^ 16'h5a5a;
  endfunction : arr
  assign rd_data = arr(rd_addr);

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  fbpc_host_model i_host (.clk_i(clk_i), .pins_o(pins), .addr_o(addr),
    .dq_o(dq_in));
  fbpc_flash_bus_ctrl i_dut (.clk_i(clk_i), .srst_i(srst_i), .pins_i(pins),
    .addr_i(addr), .dq_i(dq_in), .dq_o(dq_out), .dq_oe_o(dq_oe),
    .wait_o(wait_o), .wait_oe_o(wait_oe),
    .program_supply_lockout_level_i(lko_p), .core_lockout_level_i(lko_c),
    .rd_addr_o(rd_addr), .rd_data_i(rd_data), .arr_busy_i(busy),
    .arr_req_o(req), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata));

  // ==========
  // Compare and bus tasks
  task automatic chk_w(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t word %h exp %h", $time, g, e);
    end
  endtask : chk_w
  task automatic chk_b(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t bit %b exp %b", $time, g, e);
    end
  endtask : chk_b
  task automatic reg_wr(input logic [3:0] a, input logic [DATA_W-1:0] d);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [DATA_W-1:0] d);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    d = rdata;
    @(posedge clk_i);
  endtask : reg_rd
  task automatic cmd2(input logic [ADDR_W-1:0] a, input logic [7:0] c,
    input logic [DATA_W-1:0] d);
    i_host.wr(a, {8'h00, c});
    i_host.wr(a, d);
  endtask : cmd2
  task automatic chk_req(input int n);
    i_host.hold(3);
    chk_b(n_req == n, 1'b1);
  endtask : chk_req
  task automatic tally_and_finish();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Request monitor and hang guard; the run needs about 350 cycles.
  always @(posedge clk_i) begin
    cyc++;
    if (req.valid === 1'b1) begin
      n_req++;
      last_req = req;
    end
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  // ==========
  // Main sequence
  initial begin
    lko_p <= 1'b0;
    lko_c <= 1'b0;
    busy <= 1'b0;
    ra <= 4'h0;
    wd <= 16'h0000;
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    i_host.hold(4);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        reg_wr(rows[i].a, rows[i].d);
      end else begin
        reg_rd(rows[i].a, got);
        chk_w(got, rows[i].e);
      end
    end
    i_host.rd_on(22'h000123);
    chk_b(dq_oe, 1'b1);
    chk_w(dq_out, arr(22'h000123));
    chk_b(wait_o, 1'b0);
    reg_wr(OFS_RCR, RCR_RESET);
    i_host.hold(5);
    chk_b(wait_o, 1'b1);
    i_host.addr_o <= 22'h000456;
    i_host.hold(6);
    chk_w(dq_out, arr(22'h000456));
    i_host.pins_o.address_valid_n <= 1'b1;
    i_host.hold(4);
    i_host.addr_o <= 22'h000789;
    i_host.hold(6);
    chk_w(dq_out, arr(22'h000456));
    i_host.pins_o.oe_n <= 1'b1;
    i_host.hold(6);
    chk_b(dq_oe, 1'b0);
    chk_b(wait_oe, 1'b0);
    cmd2(BA, CMD_LOCK_SETUP, {8'h00, CMD_UNLOCK});
    cmd2(BA, CMD_PROG_SETUP, 16'hbeef);
    chk_req(1);
    chk_w(last_req.data, 16'hbeef);
    chk_b(last_req.addr == BA, 1'b1);
    cmd2(BA, CMD_LOCK_SETUP, {8'h00, CMD_LOCK_DOWN});
    i_host.pins_o.wp_n <= 1'b0;
    cmd2(BA, CMD_LOCK_SETUP, {8'h00, CMD_UNLOCK});
    cmd2(BA, CMD_PROG_SETUP, 16'h1111);
    chk_req(1);
    i_host.pins_o.wp_n <= 1'b1;
    cmd2(BA, CMD_LOCK_SETUP, {8'h00, CMD_UNLOCK});
    cmd2(BA, CMD_PROG_SETUP, 16'hcafe);
    chk_req(2);
    cmd2(BA, CMD_ERASE_SETUP, {8'h00, CMD_ERASE_CONFIRM});
    chk_req(3);
    chk_b(last_req.erase, 1'b1);
    lko_p <= 1'b1;
    cmd2(BA, CMD_PROG_SETUP, 16'h2222);
    chk_req(3);
    lko_p <= 1'b0;
    lko_c <= 1'b1;
    cmd2(BA, CMD_PROG_SETUP, 16'h3333);
    chk_req(3);
    lko_c <= 1'b0;
    reg_wr(OFS_RCR, 16'h2400);
    i_host.pins_o.rst_n <= 1'b0;
    i_host.hold(4);
    cmd2(BA, CMD_PROG_SETUP, 16'h4444);
    chk_req(3);
    busy <= 1'b1;
    reg_rd(OFS_STATUS, got);
    chk_w(got, 16'h00e9);
    busy <= 1'b0;
    reg_wr(OFS_STATUS, ST_STICKY_MASK);
    reg_rd(OFS_STATUS, got);
    chk_w(got, 16'h0109);
    i_host.pins_o.rst_n <= 1'b1;
    i_host.pins_o.address_valid_n <= 1'b0;
    i_host.hold(4);
    reg_rd(OFS_RCR, got);
    chk_w(got, RCR_RESET);
    i_host.rd_on(22'h0000aa);
    chk_w(dq_out, arr(22'h0000aa));
    i_host.pins_o.oe_n <= 1'b1;
    reg_wr(OFS_RCR, 16'h9400);
    i_host.hold(4);
    i_host.rd_on(22'h000200);
    chk_b(wait_o, 1'b1);
    i_host.bclk_pulse();
    i_host.pins_o.address_valid_n <= 1'b1;
    i_host.addr_o <= 22'h300000;
    repeat (5) i_host.bclk_pulse();
    chk_b(wait_o, 1'b0);
    chk_w(dq_out, arr(22'h000203));
    chk_b(rd_addr == 22'h000203, 1'b1);
    i_host.pins_o.ce_n <= 1'b1;
    i_host.hold(6);
    chk_b(dq_oe, 1'b0);
    chk_b(wait_oe, 1'b0);
    tally_and_finish();
  end
endmodule : tb_top
